// File: pkg/arith_cond_pkg.sv
package arith_cond_pkg;
	localparam int RES_W = 48;
	localparam int ACC_W = 40;
	localparam int DREG_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [15:0] SAT16_MAX = 16'h7FFF;
	localparam logic [15:0] SAT16_MIN = 16'h8000;
	localparam logic [31:0] SAT32_MAX = 32'h7FFF_FFFF;
	localparam logic [31:0] SAT32_MIN = 32'h8000_0000;
	localparam logic [39:0] SAT40_MAX = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT40_MIN = 40'h80_0000_0000;
	// Register offsets.
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_RESULT = 4'h1;
	localparam logic [3:0] ADDR_RESULT_HI = 4'h2;
	// Status bit positions.
	localparam int BIT_ZERO = 0;
	localparam int BIT_NEG = 1;
	localparam int BIT_QUOT = 2;
	localparam int BIT_COND = 5;
	localparam int BIT_C0 = 12;
	localparam int BIT_C0DUP = 13;
	localparam int BIT_C1 = 14;
	localparam int BIT_AV0 = 16;
	localparam int BIT_AV0S = 17;
	localparam int BIT_AV1 = 18;
	localparam int BIT_AV1S = 19;
	localparam int BIT_V = 24;
	localparam int BIT_VDUP = 25;
	localparam int BIT_VS = 26;
	localparam int BIT_RND = 8;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {
		DST_HALF = 2'b00,
		DST_DREG = 2'b01,
		DST_ACC  = 2'b10,
		DST_BYTE = 2'b11
	} dest_t;
	typedef enum logic [1:0] {
		RND_NONE  = 2'b00,
		RND_TRUNC = 2'b01,
		RND_ROUND = 2'b10
	} rnd_t;
endpackage

// File: rtl/arith_result_conditioner.sv
`timescale 1ns/1ps
module arith_result_conditioner #(
	parameter int SHIFT_W = 5
) (
	// Clock and reset.
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	// Operation issue.
	input  wire logic                       opValid,
	input  wire logic                       opAddrReg,
	input  wire logic [47:0]                opValue,
	input  wire arith_cond_pkg::dest_t      opDest,
	input  wire logic                       opAccSel,
	input  wire logic                       opSaturate,
	input  wire logic                       opSat32,
	input  wire arith_cond_pkg::rnd_t       opRound,
	input  wire logic [SHIFT_W-1:0]         opDropBits,
	input  wire logic                       opCarry,
	input  wire logic                       opAlu1,
	input  wire logic                       opQuot,
	input  wire logic                       opReportOvf,
	input  wire logic                       condSet,
	input  wire logic                       condClear,
	// Register port.
	input  wire logic [3:0]                 regAddr,
	input  wire logic [31:0]                regWdata,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	output logic [31:0]                     regRdata,
	// Results.
	output logic [39:0]                     result,
	output logic                            resultValid,
	output logic                            conditionBit,
	output logic                            roundingSelect
);
	// The reduction function takes at most five shift bits.
	if (SHIFT_W < 1 || SHIFT_W > 5) begin : g_shift_check
		$error("SHIFT_W out of range");
	end

	logic [31:0] arithStatusReg;
	logic [39:0] next_result;
	logic        next_ovf;
	logic [47:0] rounded;

	function automatic logic [47:0] reduce(input logic [47:0] v, input logic [4:0] n,
			input arith_cond_pkg::rnd_t m, input logic conv);
		logic [47:0] half;
		logic [47:0] mask;
		logic [47:0] low;
		logic [47:0] base;
		half = 48'h0000_0000_0000;
		mask = 48'h0000_0000_0000;
		low = 48'h0000_0000_0000;
		base = 48'h0000_0000_0000;
		if (n == 5'd0 || m == arith_cond_pkg::RND_NONE) begin
			reduce = v;
		end else begin
			mask = (48'h0000_0000_0001 << n) - 48'h0000_0000_0001;
			half = 48'h0000_0000_0001 << (n - 5'd1);
			low = v & mask;
			base = $signed(v) >>> n;
			if (m == arith_cond_pkg::RND_ROUND) begin
				if (low > half)
					base = base + 48'h0000_0000_0001;
				else if (low == half && (!conv || base[0]))
					base = base + 48'h0000_0000_0001;
			end
			reduce = base;
		end
	endfunction

	function automatic logic fits(input logic [47:0] v, input int w);
		logic [47:0] top;
		top = $signed(v) >>> (w - 1);
		fits = (top == 48'h0000_0000_0000) || (top == 48'hFFFF_FFFF_FFFF);
	endfunction

	always_comb begin
		rounded = reduce(opValue, 5'(opDropBits), opRound, arithStatusReg[arith_cond_pkg::BIT_RND]);
		next_result = 40'h00_0000_0000;
		next_ovf = 1'b0;
		unique case (opDest)
			arith_cond_pkg::DST_HALF: begin
				if (opSaturate && !fits(rounded, 16))
					next_result = {24'h00_0000, rounded[47] ? arith_cond_pkg::SAT16_MIN
						: arith_cond_pkg::SAT16_MAX};
				else
					next_result = {24'h00_0000, rounded[15:0]};
				next_ovf = !opSaturate && !fits(rounded, 16);
			end
			arith_cond_pkg::DST_DREG: begin
				if (opSaturate && !fits(rounded, 32))
					next_result = {8'h00, rounded[47] ? arith_cond_pkg::SAT32_MIN
						: arith_cond_pkg::SAT32_MAX};
				else
					next_result = {8'h00, rounded[31:0]};
				next_ovf = !opSaturate && !fits(rounded, 32);
			end
			arith_cond_pkg::DST_ACC: begin
				if (opSaturate && opSat32 && !fits(rounded, 32))
					next_result = rounded[47] ? {{8{1'b1}}, arith_cond_pkg::SAT32_MIN}
						: {8'h00, arith_cond_pkg::SAT32_MAX};
				else if (opSaturate && !fits(rounded, 40))
					next_result = rounded[47] ? arith_cond_pkg::SAT40_MIN
						: arith_cond_pkg::SAT40_MAX;
				else
					next_result = rounded[39:0];
				next_ovf = !opSaturate && !fits(rounded, 40);
			end
			arith_cond_pkg::DST_BYTE: begin
				next_result = {32'h0000_0000, rounded[7:0]};
				next_ovf = 1'b0;
			end
		endcase
	end

	// Flags live in one status word; address-register operations skip it.
	logic flagUpdate;
	logic swWrite;
	logic [31:0] wd;
	assign flagUpdate = opValid && !opAddrReg;
	assign swWrite = regWrite && regAddr == arith_cond_pkg::ADDR_STATUS;
	assign wd = regWdata;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arithStatusReg <= arith_cond_pkg::STATUS_RESET;
		end else begin
			if (swWrite)
				arithStatusReg <= wd;
			if (flagUpdate) begin
				arithStatusReg[arith_cond_pkg::BIT_ZERO] <= (next_result == 40'h00_0000_0000);
				arithStatusReg[arith_cond_pkg::BIT_NEG] <= opDest == arith_cond_pkg::DST_ACC
					? next_result[39] : opDest == arith_cond_pkg::DST_DREG ? next_result[31]
					: next_result[15];
				arithStatusReg[arith_cond_pkg::BIT_QUOT] <= opQuot;
				if (opAlu1) begin
					arithStatusReg[arith_cond_pkg::BIT_C1] <= opCarry;
				end else begin
					arithStatusReg[arith_cond_pkg::BIT_C0] <= opCarry;
					arithStatusReg[arith_cond_pkg::BIT_C0DUP] <= opCarry;
				end
				if (opDest == arith_cond_pkg::DST_ACC) begin
					if (opAccSel) begin
						arithStatusReg[arith_cond_pkg::BIT_AV1] <= next_ovf;
						if (next_ovf)
							arithStatusReg[arith_cond_pkg::BIT_AV1S] <= 1'b1;
					end else begin
						arithStatusReg[arith_cond_pkg::BIT_AV0] <= next_ovf;
						if (next_ovf)
							arithStatusReg[arith_cond_pkg::BIT_AV0S] <= 1'b1;
					end
				end else if (opReportOvf) begin
					arithStatusReg[arith_cond_pkg::BIT_V] <= next_ovf;
					arithStatusReg[arith_cond_pkg::BIT_VDUP] <= next_ovf;
					if (next_ovf)
						arithStatusReg[arith_cond_pkg::BIT_VS] <= 1'b1;
				end
			end
			if (condSet)
				arithStatusReg[arith_cond_pkg::BIT_COND] <= 1'b1;
			else if (condClear)
				arithStatusReg[arith_cond_pkg::BIT_COND] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			result <= 40'h00_0000_0000;
			resultValid <= 1'b0;
		end else begin
			resultValid <= opValid;
			if (opValid)
				result <= next_result;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdata <= 32'h0000_0000;
		end else if (regRead) begin
			unique case (regAddr)
				arith_cond_pkg::ADDR_STATUS: regRdata <= arithStatusReg;
				arith_cond_pkg::ADDR_RESULT: regRdata <= result[31:0];
				arith_cond_pkg::ADDR_RESULT_HI: regRdata <= {24'h00_0000, result[39:32]};
				default: regRdata <= 32'h0000_0000;
			endcase
		end else begin
			regRdata <= 32'h0000_0000;
		end
	end

	assign conditionBit = arithStatusReg[arith_cond_pkg::BIT_COND];
	assign roundingSelect = arithStatusReg[arith_cond_pkg::BIT_RND];

	property p_sticky0;
		@(posedge core_clk) disable iff (rst)
		arithStatusReg[arith_cond_pkg::BIT_AV0] && !swWrite |=> arithStatusReg[arith_cond_pkg::BIT_AV0S];
	endproperty
	a_sticky0: assert property (p_sticky0) else $error("sticky0 lost");

	property p_sticky1;
		@(posedge core_clk) disable iff (rst)
		arithStatusReg[arith_cond_pkg::BIT_AV1S] && !swWrite |=> arithStatusReg[arith_cond_pkg::BIT_AV1S];
	endproperty
	a_sticky1: assert property (p_sticky1) else $error("sticky1 dropped");

	property p_stickyv;
		@(posedge core_clk) disable iff (rst)
		arithStatusReg[arith_cond_pkg::BIT_VS] && !swWrite |=> arithStatusReg[arith_cond_pkg::BIT_VS];
	endproperty
	a_stickyv: assert property (p_stickyv) else $error("data sticky dropped");

	property p_addr_hold;
		@(posedge core_clk) disable iff (rst)
		opValid && opAddrReg && !swWrite && !condSet && !condClear |=> $stable(arithStatusReg);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("flags changed");

	property p_sat_no_ovf;
		@(posedge core_clk) disable iff (rst)
		opValid && opSaturate |-> !next_ovf;
	endproperty
	a_sat_no_ovf: assert property (p_sat_no_ovf) else $error("overflow under saturation");

	property p_sat16;
		@(posedge core_clk) disable iff (rst)
		opValid && opSaturate && opDest == arith_cond_pkg::DST_HALF && !fits(rounded, 16)
		|=> result[15:0] == arith_cond_pkg::SAT16_MAX || result[15:0] == arith_cond_pkg::SAT16_MIN;
	endproperty
	a_sat16: assert property (p_sat16) else $error("16-bit clamp wrong");

	property p_cond;
		@(posedge core_clk) disable iff (rst)
		condSet |=> conditionBit;
	endproperty
	a_cond: assert property (p_cond) else $error("condition not set");

	property p_dup;
		@(posedge core_clk) disable iff (rst)
		flagUpdate && !opAlu1
		|=> arithStatusReg[arith_cond_pkg::BIT_C0] == arithStatusReg[arith_cond_pkg::BIT_C0DUP];
	endproperty
	a_dup: assert property (p_dup) else $error("duplicate flag diverged");

	// An overflow event on each flag group, as seen while the operation is issued.
	sequence s_acc0_ovf;
		flagUpdate && opDest == arith_cond_pkg::DST_ACC && !opAccSel && next_ovf;
	endsequence

	sequence s_acc1_ovf;
		flagUpdate && opDest == arith_cond_pkg::DST_ACC && opAccSel && next_ovf;
	endsequence

	sequence s_dreg_ovf;
		flagUpdate && opDest != arith_cond_pkg::DST_ACC && opReportOvf && next_ovf;
	endsequence

	property p_av0_set;
		@(posedge core_clk) disable iff (rst)
		s_acc0_ovf
		|=> arithStatusReg[arith_cond_pkg::BIT_AV0] && arithStatusReg[arith_cond_pkg::BIT_AV0S];
	endproperty
	a_av0_set: assert property (p_av0_set) else $error("acc0 overflow not flagged");

	property p_av1_set;
		@(posedge core_clk) disable iff (rst)
		s_acc1_ovf
		|=> arithStatusReg[arith_cond_pkg::BIT_AV1] && arithStatusReg[arith_cond_pkg::BIT_AV1S];
	endproperty
	a_av1_set: assert property (p_av1_set) else $error("acc1 overflow not flagged");

	property p_v_set;
		@(posedge core_clk) disable iff (rst)
		s_dreg_ovf
		|=> arithStatusReg[arith_cond_pkg::BIT_V] && arithStatusReg[arith_cond_pkg::BIT_VDUP]
			&& arithStatusReg[arith_cond_pkg::BIT_VS];
	endproperty
	a_v_set: assert property (p_v_set) else $error("data overflow not flagged");

	property p_sticky0_hold;
		@(posedge core_clk) disable iff (rst)
		arithStatusReg[arith_cond_pkg::BIT_AV0S] && !swWrite
		|=> arithStatusReg[arith_cond_pkg::BIT_AV0S];
	endproperty
	a_sticky0_hold: assert property (p_sticky0_hold) else $error("sticky0 dropped");

	property p_sat_flag;
		@(posedge core_clk) disable iff (rst)
		flagUpdate && opSaturate && opDest == arith_cond_pkg::DST_ACC && !opAccSel
		|=> !arithStatusReg[arith_cond_pkg::BIT_AV0];
	endproperty
	a_sat_flag: assert property (p_sat_flag) else $error("saturated op flagged overflow");

	property p_dup_ovf;
		@(posedge core_clk) disable iff (rst)
		flagUpdate && opDest != arith_cond_pkg::DST_ACC && opReportOvf
		|=> arithStatusReg[arith_cond_pkg::BIT_V] == arithStatusReg[arith_cond_pkg::BIT_VDUP];
	endproperty
	a_dup_ovf: assert property (p_dup_ovf) else $error("overflow copy diverged");

	property p_sat32;
		@(posedge core_clk) disable iff (rst)
		opValid && opSaturate && opDest == arith_cond_pkg::DST_DREG && !fits(rounded, 32)
		|=> result[31:0] == ($past(rounded[47]) ? arith_cond_pkg::SAT32_MIN
			: arith_cond_pkg::SAT32_MAX);
	endproperty
	a_sat32: assert property (p_sat32) else $error("32-bit clamp wrong");

	property p_sat40;
		@(posedge core_clk) disable iff (rst)
		opValid && opSaturate && !opSat32 && opDest == arith_cond_pkg::DST_ACC
			&& !fits(rounded, 40)
		|=> result == ($past(rounded[47]) ? arith_cond_pkg::SAT40_MIN
			: arith_cond_pkg::SAT40_MAX);
	endproperty
	a_sat40: assert property (p_sat40) else $error("40-bit clamp wrong");

	property p_wrap;
		@(posedge core_clk) disable iff (rst)
		opValid && !opSaturate && opDest == arith_cond_pkg::DST_DREG
		|=> result[31:0] == $past(rounded[31:0]);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrapped result wrong");

	property p_cond_clr;
		@(posedge core_clk) disable iff (rst)
		condClear && !condSet |=> !conditionBit;
	endproperty
	a_cond_clr: assert property (p_cond_clr) else $error("condition not cleared");

	property p_zero;
		@(posedge core_clk) disable iff (rst)
		flagUpdate |=> arithStatusReg[arith_cond_pkg::BIT_ZERO] == (result == 40'h00_0000_0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_result_valid;
		@(posedge core_clk) disable iff (rst)
		opValid |=> resultValid;
	endproperty
	a_result_valid: assert property (p_result_valid) else $error("result valid missing");

	property p_rdata_idle;
		@(posedge core_clk) disable iff (rst)
		!regRead |=> regRdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule // arith_result_conditioner

// File: verif/arith_result_conditioner_tb_top.sv
`timescale 1ns/1ps
module arith_result_conditioner_tb_top;
	logic                  core_clk = 1'b0, rst = 1'b1, opValid = 1'b0, opAddrReg = 1'b0;
	logic                  opAccSel = 1'b0, opSaturate = 1'b0, opSat32 = 1'b0, opCarry = 1'b0;
	logic                  opAlu1 = 1'b0, condSet = 1'b0, condClear = 1'b0;
	logic                  opQuot = 1'b0, opReportOvf = 1'b1, qt = 1'b0, rov = 1'b1;
	logic                  regWrite = 1'b0, regRead = 1'b0, cy = 1'b0, a1 = 1'b0, adr = 1'b0;
	logic [47:0]           opValue = 48'h0;
	arith_cond_pkg::dest_t opDest = arith_cond_pkg::DST_ACC;
	arith_cond_pkg::rnd_t  opRound = arith_cond_pkg::RND_NONE;
	logic [4:0]            opDropBits = 5'h0;
	logic [3:0]            regAddr = 4'h0;
	logic [31:0]           regWdata = 32'h0, regRdata, st, prev;
	logic [39:0]           result;
	logic                  resultValid, conditionBit, roundingSelect;
	int                    n_fail = 0, checked = 0, cyc = 0;

	arith_result_conditioner dut_u (.core_clk(core_clk), .rst(rst), .opValid(opValid),
		.opAddrReg(opAddrReg), .opValue(opValue), .opDest(opDest), .opAccSel(opAccSel),
		.opSaturate(opSaturate), .opSat32(opSat32), .opRound(opRound),
		.opDropBits(opDropBits), .opCarry(opCarry), .opAlu1(opAlu1), .opQuot(opQuot),
		.opReportOvf(opReportOvf), .condSet(condSet), .condClear(condClear), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.result(result), .resultValid(resultValid), .conditionBit(conditionBit),
		.roundingSelect(roundingSelect));

	always #5 core_clk = ~core_clk;

	task automatic final_report();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Rounded results come back shifted down by the dropped bit count.
	task automatic chkq(input string nm, input logic [39:0] q);
		checked++;
		if (result !== q) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, q, result);
		end
	endtask

	task automatic op(input logic [47:0] v, input arith_cond_pkg::dest_t d, input logic sat,
		input logic s32, input arith_cond_pkg::rnd_t r, input logic [4:0] db);
		@(posedge core_clk);
		opValid <= 1'b1;
		opValue <= v;
		opDest <= d;
		opSaturate <= sat;
		opSat32 <= s32;
		opRound <= r;
		opDropBits <= db;
		opCarry <= cy;
		opAlu1 <= a1;
		opAccSel <= a1;
		opAddrReg <= adr;
		opQuot <= qt;
		opReportOvf <= rov;
		@(posedge core_clk);
		opValid <= 1'b0;
		#1;
		chk("resultValid", 40'h1, {39'h0, resultValid});
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		st = regRdata;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	task automatic cnd(input logic s, input logic c);
		@(posedge core_clk);
		condSet <= s;
		condClear <= c;
		@(posedge core_clk);
		condSet <= 1'b0;
		condClear <= 1'b0;
		#1;
	endtask

	task automatic sc(input logic [47:0] v, input arith_cond_pkg::dest_t d, input logic s32,
		input logic [39:0] e, input logic [39:0] m);
		op(v, d, 1'b1, s32, arith_cond_pkg::RND_NONE, 5'h0);
		chk("satResult", e, result & m);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0);
		chk("statusReset", 40'h0, {8'h0, st});
		rd(4'hF);
		chk("unmapped", 40'h0, {8'h0, st});
		$display("test reset done");
		sc(48'h0000_0001_0000, arith_cond_pkg::DST_HALF, 1'b0, 40'h7FFF, 40'hFFFF);
		sc(48'hFFFF_FFFF_0000, arith_cond_pkg::DST_HALF, 1'b0, 40'h8000, 40'hFFFF);
		sc(48'h0001_0000_0000, arith_cond_pkg::DST_DREG, 1'b0, 40'h7FFF_FFFF, 40'hFFFF_FFFF);
		sc(48'hFFFE_0000_0000, arith_cond_pkg::DST_DREG, 1'b0, 40'h8000_0000, 40'hFFFF_FFFF);
		sc(48'h0100_0000_0000, arith_cond_pkg::DST_ACC, 1'b0, 40'h7F_FFFF_FFFF, '1);
		sc(48'hFF00_0000_0000, arith_cond_pkg::DST_ACC, 1'b0, 40'h80_0000_0000, '1);
		sc(48'h0000_8000_0000, arith_cond_pkg::DST_ACC, 1'b1, 40'h00_7FFF_FFFF, '1);
		sc(48'hFFFF_0000_0000, arith_cond_pkg::DST_ACC, 1'b1, 40'hFF_8000_0000, '1);
		rd(4'h0);
		chk("satFlags", 40'h0, {37'h0, st[26], st[24], st[16]});
		$display("test saturation done");
		for (int k = 0; k < 2; k++) begin
			a1 = k[0];
			op(48'h0100_0000_0005, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
			chk("accWrap", 40'h5, result);
			rd(4'h0);
			chk("accOvf", 40'h3, {38'h0, st[17+2*k], st[16+2*k]});
			op(48'h1, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
			rd(4'h0);
			chk("accSticky", 40'h2, {38'h0, st[17+2*k], st[16+2*k]});
			wr(4'h0, 32'h0);
			rd(4'h0);
			chk("accStickyClr", 40'h0, {39'h0, st[17+2*k]});
		end
		a1 = 1'b0;
		op(48'h0001_0000_0003, arith_cond_pkg::DST_DREG, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		chk("dregWrap", 40'h3, result & 40'hFFFF_FFFF);
		rd(4'h0);
		chk("dregOvf", 40'h7, {37'h0, st[26:24]});
		op(48'h1, arith_cond_pkg::DST_DREG, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		rd(4'h0);
		chk("dregSticky", 40'h4, {37'h0, st[26:24]});
		prev = st;
		adr = 1'b1;
		op(48'h0100_0000_0000, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		adr = 1'b0;
		rd(4'h0);
		chk("addrRegFlags", {8'h0, prev}, {8'h0, st});
		$display("test overflow done");
		cy = 1'b1;
		op(48'h0, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		rd(4'h0);
		chk("carry0Zero", 40'h0D, {35'h0, st[14:12], st[1:0]});
		a1 = 1'b1;
		op(48'hFFFF_FFFF_FFFF, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		rd(4'h0);
		chk("carry1Neg", 40'h6, {37'h0, st[14], st[1], st[0]});
		cy = 1'b0;
		a1 = 1'b0;
		cnd(1'b1, 1'b0);
		chk("condSet", 40'h1, {39'h0, conditionBit});
		rd(4'h0);
		chk("condStatus", 40'h1, {39'h0, st[5]});
		cnd(1'b0, 1'b1);
		chk("condClear", 40'h0, {39'h0, conditionBit});
		$display("test flags done");
		for (int m = 0; m < 2; m++) begin
			wr(4'h0, 32'(m) << 8);
			#1;
			chk("roundSel", 40'(m), {39'h0, roundingSelect});
			op(48'h2, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_ROUND, 5'h2);
			chkq("roundHalfLow", m ? 40'h0 : 40'h1);
			op(48'hA, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_ROUND, 5'h2);
			chkq("roundHalfHigh", m ? 40'h2 : 40'h3);
			op(48'h7, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_ROUND, 5'h2);
			chkq("roundNear", 40'h2);
			op(48'h7, arith_cond_pkg::DST_ACC, 1'b0, 1'b0, arith_cond_pkg::RND_TRUNC, 5'h2);
			chkq("truncate", 40'h1);
		end
		$display("test rounding done");
		qt = 1'b1;
		rov = 1'b0;
		op(48'h8000, arith_cond_pkg::DST_HALF, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		qt = 1'b0;
		rov = 1'b1;
		chk("halfWrap", 40'h8000, result);
		rd(4'h0);
		chk("halfSign", 40'h3, {37'h0, st[24], st[2], st[1]});
		op(48'h01FF, arith_cond_pkg::DST_BYTE, 1'b0, 1'b0, arith_cond_pkg::RND_NONE, 5'h0);
		chk("byteResult", 40'hFF, result);
		rd(4'h0);
		chk("byteFlags", 40'h0, {37'h0, st[24], st[1], st[0]});
		$display("test width done");
		final_report();
	end
endmodule // arith_result_conditioner_tb_top
